//--- bench/serial_port_tb.sv
// self-checking bench for the clocked serial port
`timescale 1ns/1ps
module serial_port_tb;
  import sp_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] d;
  logic sck_o, sck_oe, so, si, far_clk;
  wire sck_line = sck_oe ? sck_o : far_clk;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int dv [8] = '{1024, 256, 64, 32, 16, 8, 4, 2};
  // 25 MHz clock
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  serial_port i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .serial_clk_pin_i(sck_line), .serial_clk_pin_o(sck_o),
    .serial_clk_pin_oe_o(sck_oe), .serial_in_pin_i(si), .serial_out_pin_o(so));
  sp_far_end far (.mclk_i(mclk_i), .line_clk_i(sck_line), .data_i(so), .clk_o(far_clk), .data_o(si));
  // bus write, one strobe cycle
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    #1;
  endtask
  // bus read, data taken the cycle after the strobe
  task rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task ck(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a, d);
    ck(d, e);
  endtask
  // poll until the start flag drops
  task wt;
    for (int i = 0; i < 6000; i++) begin
      rd_reg(ADDR_STATUS, d);
      if (d[STAT_START] === 1'b0) break;
    end
    ck(d[STAT_START], 1'b0);
  endtask
  // mclk cycles between two falls of the driven clock
  task per(input int n);
    int k, t, f;
    logic p;
    k = 0;
    t = 0;
    f = 0;
    p = sck_o;
    while (f < 2 && k < 3000) begin
      @(posedge mclk_i);
      #1;
      k++;
      if (p && !sck_o) begin
        f++;
        t = (f == 1) ? k : k - t;
      end
      p = sck_o;
    end
    ck(16'(t), 16'(n));
  endtask
  task t_rst;
    rc(ADDR_CTRL, 8'h00);
    rc(ADDR_STATUS, 8'h80);
    rc(8'h10, 8'h00);
    $display("reset test done");
  endtask
  // every divider code; /2 allowed since the clock is not 5 MHz
  task t_div;
    for (int c = 0; c < 8; c++) begin
      wr_reg(ADDR_CTRL, 8'(c));
      wr_reg(ADDR_STATUS, 8'h01);
      per(dv[c]);
      ck(sck_oe, 1'b1);
      wt;
    end
    $display("divider test done");
  endtask
  task t_8;
    wr_reg(ADDR_DATA_HI, 8'h77);
    wr_reg(ADDR_DATA_LO, 8'hA5);
    wr_reg(ADDR_CTRL, 8'h05);
    far.load(16'h003C);
    wr_reg(ADDR_STATUS, 8'h01);
    wt;
    far.drop_line;
    rc(ADDR_DATA_LO, 8'h3C);
    rc(ADDR_DATA_HI, 8'h77);
    ck(far.rx[15:8], 8'hA5);
    ck(so, 1'b1);
    $display("byte test done");
  endtask
  task t_16;
    wr_reg(ADDR_DATA_HI, 8'hC3);
    wr_reg(ADDR_DATA_LO, 8'h5A);
    wr_reg(ADDR_CTRL, 8'h45);
    far.load(16'h1234);
    wr_reg(ADDR_STATUS, 8'h01);
    wt;
    far.drop_line;
    rc(ADDR_DATA_HI, 8'h12);
    rc(ADDR_DATA_LO, 8'h34);
    ck(far.rx, 16'hC35A);
    $display("word test done");
  endtask
  task t_ext;
    wr_reg(ADDR_CTRL, 8'h08);
    ck(sck_oe, 1'b0);
    wr_reg(ADDR_DATA_LO, 8'h96);
    far.load(16'h00E1);
    wr_reg(ADDR_STATUS, 8'h01);
    far.pulse(8, 6);
    repeat (6) @(posedge mclk_i);
    wt;
    rc(ADDR_DATA_LO, 8'hE1);
    ck(far.rx[15:8], 8'h96);
    far.pulse(1, 6);
    repeat (6) @(posedge mclk_i);
    rc(ADDR_STATUS, 8'hE0);
    wr_reg(ADDR_STATUS, 8'h60);
    rc(ADDR_STATUS, 8'hE0);
    wr_reg(ADDR_STATUS, 8'h40);
    rc(ADDR_STATUS, 8'hC0);
    far.pulse(1, 6);
    repeat (6) @(posedge mclk_i);
    wr_reg(ADDR_STATUS, 8'h40);
    rc(ADDR_STATUS, 8'hE0);
    $display("external clock test done");
  endtask
  task t_lvl;
    wr_reg(ADDR_STATUS, 8'h00);
    ck(so, 1'b0);
    rc(ADDR_STATUS, 8'h80);
    wr_reg(ADDR_STATUS, 8'h40);
    ck(so, 1'b1);
    rc(ADDR_STATUS, 8'hC0);
    $display("level test done");
  endtask
  task t_cont;
    logic hold;
    wr_reg(ADDR_CTRL, 8'h86);
    per(4);
    @(posedge mclk_i);
    ce <= 1'b0;
    @(posedge mclk_i);
    #1;
    hold = sck_o;
    repeat (6) @(posedge mclk_i);
    #1;
    ck(sck_o, hold);
    @(posedge mclk_i);
    ce <= 1'b1;
    per(4);
    wr_reg(ADDR_STATUS, 8'h01);
    rc(ADDR_STATUS, 8'h80);
    wr_reg(ADDR_CTRL, 8'hF6);
    rc(ADDR_CTRL, 8'hF6);
    wr_reg(ADDR_STATUS, 8'h01);
    rc(ADDR_STATUS, 8'h80);
    ck(sck_o, 1'b1);
    wr_reg(ADDR_CTRL, 8'h00);
    $display("continuous clock test done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      $display("CHECK FAILED t=%0t timeout", $time);
      conclude;
    end
  end
  // main sequence
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_rst;
    t_div;
    t_8;
    t_16;
    t_ext;
    t_lvl;
    t_cont;
    conclude;
  end
endmodule

//--- bench/sp_far_end.sv
// far-end synchronous serial device model for the serial port bench
`timescale 1ns/1ps
module sp_far_end (
  // clock and line levels
  input wire logic mclk_i,
  input wire logic line_clk_i,
  input wire logic data_i,
  // far-end drives
  output logic clk_o,
  output logic data_o
);
  logic [15:0] tx = 16'h0000;
  logic [15:0] rx = 16'h0000;
  // own clock idles high between bursts
  initial begin
    clk_o = 1'b1;
    data_o = 1'b0;
  end
  // next bit goes out on the falling edge, lsb first
  always @(negedge line_clk_i) begin
    data_o <= tx[0];
    tx <= {1'b0, tx[15:1]};
  end
  // device bit is captured on the rising edge
  always @(posedge line_clk_i) begin
    rx <= {data_i, rx[15:1]};
  end
  // word to send in the next frame
  task load(input logic [15:0] w);
    tx = w;
  endtask
  // line no longer held: show the inverse of the last bit
  task drop_line;
    @(posedge mclk_i);
    data_o <= ~data_o;
  endtask
  // burst of clock pulses supplied from outside the device
  task pulse(input int n, input int half);
    repeat (n) begin
      @(posedge mclk_i);
      clk_o <= 1'b0;
      repeat (half) @(posedge mclk_i);
      clk_o <= 1'b1;
      repeat (half - 1) @(posedge mclk_i);
    end
  endtask
endmodule

//--- design/serial_port.sv
// clocked 8/16-bit synchronous serial port with byte register access
// Contract
// - divider code 000..111 selects clock/1024,256,64,32,16,8,4,2
// - internal source: shift on prescaler clock and drive it on clock pin
// - external source: clock pin is input, shift on external clock
// - mode 00 is 8-bit transfer, mode 01 is 16-bit transfer
// - mode 10 outputs clock continuously on internal source only; mode 11 reserved
// - start flag reads 1 while busy; write 1 starts in modes 00/01 only, write 0 ignored
// - external clock pulse after completion sets overrun flag
// - overrun cleared by writing 0 after reading 1; writing 1 ignored
// - writing output level bit drives serial output pin at once
// - reading output level bit returns serial output pin level
// - upper buffer holds tx/rx data, unused in 8-bit mode
// - 16-bit mode: upper buffer carries the most significant byte
// - 16-bit mode: lower buffer carries the least significant byte
// - 8-bit mode: lower buffer alone holds sent and received byte
`timescale 1ns/1ps
module serial_port (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // serial pins
  input wire logic serial_clk_pin_i,
  output logic serial_clk_pin_o,
  output logic serial_clk_pin_oe_o,
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o
);
  import sp_pkg::*;

  typedef struct packed {
    sp_state_t st;
    logic [7:0] ctrl_reg;
    logic [7:0] data_hi_buf;
    logic [7:0] data_lo_buf;
    logic out_level_bit;
    logic sck;
    logic overrun_flag;
    logic overrun_seen;
    logic [4:0] bits;
    logic [7:0] rdata;
    logic [1:0] sck_sync;
    logic sck_prev;
    logic [1:0] si_sync;
  } sp_regs_t;

  sp_regs_t r;
  sp_regs_t next_r;
  sp_clk_if clk_if ();

  logic clk_src_sel;
  logic [1:0] op_mode;
  logic xfer_start_flag;
  logic ext_rise;
  logic ext_fall;
  logic shift_rise;
  logic shift_fall;
  logic [4:0] xfer_len;
  logic wr_ctrl;
  logic wr_status;
  logic wr_hi;
  logic wr_lo;
  logic rd_status;

  // control fields and decoded strobes
  assign clk_src_sel = r.ctrl_reg[CTRL_CLK_SRC];
  assign op_mode = r.ctrl_reg[CTRL_MODE_HI:CTRL_MODE_LO];
  assign xfer_start_flag = (r.st == ST_XFER);
  assign xfer_len = (op_mode == MODE_16BIT) ? BITS_16 : BITS_8;
  assign wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
  assign wr_status = wr_i && (addr_i == ADDR_STATUS);
  assign wr_hi = wr_i && (addr_i == ADDR_DATA_HI);
  assign wr_lo = wr_i && (addr_i == ADDR_DATA_LO);
  assign rd_status = rd_i && (addr_i == ADDR_STATUS);

  // edges of the synchronised external clock
  assign ext_rise = r.sck_sync[1] && !r.sck_prev;
  assign ext_fall = !r.sck_sync[1] && r.sck_prev;

  // prescaler hookup
  assign clk_if.div_sel = r.ctrl_reg[CTRL_DIV_HI:CTRL_DIV_LO];
  assign clk_if.run = !clk_src_sel && (r.st != ST_IDLE);

  sp_prescaler u_prescaler (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clk_if(clk_if)
  );

  // shift edges from the selected clock source
  always_comb begin
    shift_rise = 1'b0;
    shift_fall = 1'b0;
    if (r.st == ST_XFER) begin
      if (clk_src_sel) begin
        shift_rise = ext_rise;
        shift_fall = ext_fall;
      end else begin
        shift_rise = clk_if.tick && !r.sck;
        shift_fall = clk_if.tick && r.sck;
      end
    end
  end

  // pin drive: clock output only on internal source
  assign serial_clk_pin_oe_o = !clk_src_sel;
  assign serial_clk_pin_o = r.sck;
  assign serial_out_pin_o = r.out_level_bit;
  assign rdata_o = r.rdata;

  // next state: shifting first, then bus writes, then overrun and read data
  always_comb begin
    next_r = r;
    // both pins pass two flops before any logic reads them
    next_r.sck_sync = {r.sck_sync[0], serial_clk_pin_i};
    next_r.sck_prev = r.sck_sync[1];
    next_r.si_sync = {r.si_sync[0], serial_in_pin_i};
    unique case (r.st)
      ST_IDLE: begin
        next_r.sck = 1'b1;
        if (op_mode == MODE_CONT && !clk_src_sel) begin
          next_r.st = ST_CONT;
        end
      end
      ST_XFER: begin
        if (!clk_src_sel && clk_if.tick) begin
          next_r.sck = !r.sck;
        end
        if (shift_fall) begin
          next_r.out_level_bit = r.data_lo_buf[0];
        end
        if (shift_rise) begin
          // received bit is the second sync flop, two cycles behind the pin
          if (op_mode == MODE_16BIT) begin
            next_r.data_hi_buf = {r.si_sync[1], r.data_hi_buf[7:1]};
            next_r.data_lo_buf = {r.data_hi_buf[0], r.data_lo_buf[7:1]};
          end else begin
            next_r.data_lo_buf = {r.si_sync[1], r.data_lo_buf[7:1]};
          end
          next_r.bits = 5'(r.bits + 5'h01);
          if (r.bits == 5'(xfer_len - 5'h01)) begin
            next_r.st = ST_IDLE;
            next_r.bits = 5'h00;
            next_r.sck = 1'b1;
          end
        end
      end
      ST_CONT: begin
        if (clk_if.tick) begin
          next_r.sck = !r.sck;
        end
        if (op_mode != MODE_CONT || clk_src_sel) begin
          next_r.st = ST_IDLE;
          next_r.sck = 1'b1;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
    // register writes
    if (wr_ctrl) begin
      next_r.ctrl_reg = wdata_i;
    end
    if (wr_hi) begin
      next_r.data_hi_buf = wdata_i;
    end
    if (wr_lo) begin
      next_r.data_lo_buf = wdata_i;
    end
    if (wr_status) begin
      next_r.out_level_bit = wdata_i[STAT_OUT_LEVEL];
      // start refused while busy or in the clock-output and reserved modes
      if (wdata_i[STAT_START] && r.st == ST_IDLE && !op_mode[1]) begin
        next_r.st = ST_XFER;
        next_r.bits = 5'h00;
        next_r.sck = 1'b1;
      end
      if (!wdata_i[STAT_OVERRUN] && r.overrun_seen) begin
        next_r.overrun_flag = 1'b0;
        next_r.overrun_seen = 1'b0;
      end
    end
    // overrun remembered once software has seen it
    if (rd_status && r.overrun_flag) begin
      next_r.overrun_seen = 1'b1;
    end
    // set wins over a clear in the same cycle
    if (clk_src_sel && ext_rise && r.st == ST_IDLE) begin
      next_r.overrun_flag = 1'b1;
    end
    // read data for the following cycle
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CTRL: next_r.rdata = r.ctrl_reg;
        ADDR_STATUS: next_r.rdata = {1'b1, r.out_level_bit, r.overrun_flag, 4'h0, xfer_start_flag};
        ADDR_DATA_HI: next_r.rdata = r.data_hi_buf;
        ADDR_DATA_LO: next_r.rdata = r.data_lo_buf;
        // unmapped addresses read as zero
        default: next_r.rdata = 8'h00;
      endcase
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      r <= '{st: ST_IDLE, ctrl_reg: CTRL_RST, data_hi_buf: 8'h00, data_lo_buf: 8'h00,
             out_level_bit: 1'b0, sck: 1'b1, overrun_flag: 1'b0, overrun_seen: 1'b0,
             bits: 5'h00, rdata: 8'h00, sck_sync: 2'h3, sck_prev: 1'b1, si_sync: 2'h0};
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // checks
  a_int_clk_out: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !clk_src_sel |-> serial_clk_pin_oe_o)
    else $error("internal clock not driven on pin");
  a_ext_clk_in: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    clk_src_sel |-> !serial_clk_pin_oe_o && !clk_if.run)
    else $error("pin driven or prescaler running with external clock");
  a_start_sets: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && wr_status && wdata_i[STAT_START] && r.st == ST_IDLE && !op_mode[1] && !wr_ctrl)
    |=> xfer_start_flag ##1 (!ce_i || xfer_start_flag || r.bits == 5'h00))
    else $error("writing 1 to start flag did not start");
  a_start_write0: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && wr_status && !wdata_i[STAT_START] && !xfer_start_flag) |=> !xfer_start_flag)
    else $error("writing 0 to start flag started a transfer");
  a_done_clears: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && shift_rise && r.bits == 5'(xfer_len - 5'h01)) |=> !xfer_start_flag && r.bits == 5'h00)
    else $error("start flag not cleared after last bit");
  a_overrun_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && clk_src_sel && ext_rise && r.st == ST_IDLE) |=> r.overrun_flag)
    else $error("late external clock did not set overrun");
  a_overrun_no_clr: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && r.overrun_flag && !r.overrun_seen && !rd_status) |=> r.overrun_flag)
    else $error("overrun cleared without a prior read");
  a_level_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && wr_status) |=> serial_out_pin_o == $past(wdata_i[STAT_OUT_LEVEL]))
    else $error("output pin did not follow level write");
  a_level_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && rd_status) |=> rdata_o[STAT_OUT_LEVEL] == $past(serial_out_pin_o))
    else $error("level bit read does not match pin");
  a_hi_untouched: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (xfer_start_flag && op_mode == MODE_8BIT && !wr_hi) |=> $stable(r.data_hi_buf))
    else $error("upper buffer changed in 8-bit mode");
  a_cont_toggle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && r.st == ST_CONT && clk_if.tick && op_mode == MODE_CONT && !clk_src_sel && !wr_ctrl)
    |=> serial_clk_pin_o != $past(serial_clk_pin_o))
    else $error("continuous clock did not toggle");
  // internal source: every prescaler tick during a transfer moves the driven clock
  a_int_shift_clk: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && r.st == ST_XFER && !clk_src_sel && clk_if.tick)
    |=> serial_clk_pin_o != $past(serial_clk_pin_o))
    else $error("internal shift clock did not toggle on tick");
  // external source: the driven clock level is left alone during a transfer
  a_ext_clk_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && clk_src_sel && r.st == ST_XFER && serial_clk_pin_o) |=> serial_clk_pin_o)
    else $error("clock drive moved while external clock selected");
  // clock pin drive idles high whenever nothing runs
  a_idle_clk_high: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (r.st == ST_IDLE) |-> serial_clk_pin_o)
    else $error("clock drive not high while idle");
  // start write refused in the clock-output and reserved modes
  a_start_refused: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && wr_status && wdata_i[STAT_START] && op_mode[1] && !xfer_start_flag) |=> !xfer_start_flag)
    else $error("transfer started in clock-output or reserved mode");
  // 16-bit mode does not stop after the eighth bit
  a_len_16: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && shift_rise && op_mode == MODE_16BIT && r.bits == 5'h07) |=> xfer_start_flag)
    else $error("16-bit transfer stopped after eight bits");
  // 8-bit mode: received bit enters the top of the lower buffer
  a_lo_shift_8: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && shift_rise && op_mode != MODE_16BIT && !wr_lo) |=> r.data_lo_buf[7] == $past(r.si_sync[1]))
    else $error("8-bit receive bit not captured in lower buffer");
  // 16-bit mode: received bit enters the top of the upper buffer
  a_hi_shift_16: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && shift_rise && op_mode == MODE_16BIT && !wr_hi) |=> r.data_hi_buf[7] == $past(r.si_sync[1]))
    else $error("16-bit receive bit not captured in upper buffer");
  // 16-bit mode: upper buffer bit 0 moves into the lower buffer
  a_lo_from_hi: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && shift_rise && op_mode == MODE_16BIT && !wr_lo) |=> r.data_lo_buf[7] == $past(r.data_hi_buf[0]))
    else $error("lower buffer did not take upper buffer bit 0");
  // on a falling shift edge lower buffer bit 0 goes out
  a_out_on_fall: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && shift_fall && !wr_status) |=> serial_out_pin_o == $past(r.data_lo_buf[0]))
    else $error("output pin did not take lower buffer bit 0");
  // a write of 0 after a read of 1 clears overrun unless a new pulse lands
  a_overrun_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && wr_status && !wdata_i[STAT_OVERRUN] && r.overrun_seen
     && !(clk_src_sel && ext_rise && r.st == ST_IDLE)) |=> !r.overrun_flag)
    else $error("overrun not cleared by write of 0 after read");
endmodule

//--- design/sp_clk_if.sv
// prescaler request and tick between the port and its divider
`timescale 1ns/1ps
interface sp_clk_if;
  logic [2:0] div_sel;
  logic run;
  logic tick;
  modport src (input div_sel, input run, output tick);
  modport user (output div_sel, output run, input tick);
endinterface

//--- design/sp_pkg.sv
// constants, register map and types for the clocked serial port
package sp_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'hA0;
  localparam logic [7:0] ADDR_STATUS = 8'hA1;
  localparam logic [7:0] ADDR_DATA_HI = 8'hA2;
  localparam logic [7:0] ADDR_DATA_LO = 8'hA3;
  // control field positions
  localparam int CTRL_MODE_HI = 7;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_CLK_SRC = 3;
  localparam int CTRL_DIV_HI = 2;
  localparam int CTRL_DIV_LO = 0;
  // status field positions
  localparam int STAT_FIXED = 7;
  localparam int STAT_OUT_LEVEL = 6;
  localparam int STAT_OVERRUN = 5;
  localparam int STAT_START = 0;
  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h80;
  // operation modes
  localparam logic [1:0] MODE_8BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  // bit counts per transfer
  localparam logic [4:0] BITS_8 = 5'h08;
  localparam logic [4:0] BITS_16 = 5'h10;
  // half-period masks per divider code: 1024,256,64,32,16,8,4,2
  localparam int DIV_CNT_W = 9;
  localparam logic [8:0] DIV_HALF_MASK [0:7] = '{9'h1FF, 9'h07F, 9'h01F, 9'h00F,
                                                9'h007, 9'h003, 9'h001, 9'h000};
  // transfer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_CONT = 3'b100
  } sp_state_t;
endpackage

//--- design/sp_prescaler.sv
// divider that marks each half period of the internal serial clock
`timescale 1ns/1ps
module sp_prescaler (
  // clock and control
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // divider link
  sp_clk_if.src clk_if
);
  import sp_pkg::*;

  typedef struct packed {
    logic [DIV_CNT_W-1:0] cnt;
  } pre_regs_t;

  pre_regs_t r;
  pre_regs_t next_r;
  logic [8:0] mask;

  // selected half-period mask
  assign mask = DIV_HALF_MASK[clk_if.div_sel];
  assign clk_if.tick = clk_if.run && ((r.cnt & mask) == mask);

  // counter restarts whenever the clock is not wanted
  always_comb begin
    next_r = r;
    next_r.cnt = clk_if.run ? DIV_CNT_W'(r.cnt + 9'h001) : '0;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // a tick at divide-by-2 comes on every running cycle
  a_div2_every: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (clk_if.run && clk_if.div_sel == 3'h7) |-> clk_if.tick)
    else $error("divide-by-2 missed a half period");
  // after a tick the next one is a full half period away
  a_div_spacing: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && clk_if.tick && clk_if.div_sel == 3'h6) |=> (clk_if.run && ce_i) |-> !clk_if.tick)
    else $error("divide-by-4 tick came too early");
endmodule
